// *** design/kmp_regs.vh ***
/*
  Register offsets, field positions, reset values and timing counts for the keyboard/mouse serial port pair.
  Assumes a 20 MHz pclk and APB byte addressing with one word per register.
*/
`ifndef KMP_REGS_VH
`define KMP_REGS_VH
// Per-port window and register offsets
`define KMP_PORT_SEL_BIT 8
`define KMP_OFF_ID 4'h0
`define KMP_OFF_DATA 4'h4
`define KMP_OFF_CTRL 4'h8
`define KMP_OFF_STAT 4'hc
`define KMP_OFF_IRQ_STAT 12'h200
`define KMP_OFF_IRQ_MASK 12'h204
// Identity codes, arbitrary values
`define KMP_ID_KBD 4'h5
`define KMP_ID_MSE 4'ha
// Control fields
`define KMP_CTRL_RESET 8'h00
`define KMP_CTRL_ON 0
`define KMP_CTRL_LOOP 1
`define KMP_CTRL_DIAG 5
`define KMP_CTRL_DAT 6
`define KMP_CTRL_CLK 7
// Status fields
`define KMP_ST_RXNE 0
`define KMP_ST_TXP 1
`define KMP_ST_TERR 2
`define KMP_ST_PERR 3
`define KMP_ST_CMP 4
`define KMP_ST_DSHD 6
`define KMP_ST_CSHD 7
// Receive buffer
`define KMP_RX_DEPTH 4
// Timing
`define KMP_PCLK_MHZ 20
`define KMP_INHIBIT_US 100
`define KMP_INHIBIT_CYC (`KMP_INHIBIT_US * `KMP_PCLK_MHZ)
`define KMP_LOOP_KHZ 2000
`define KMP_LOOP_DIV ((`KMP_PCLK_MHZ * 1000) / (2 * `KMP_LOOP_KHZ))
`define KMP_TMO_US 2000
`define KMP_TMO_CYC (`KMP_TMO_US * `KMP_PCLK_MHZ)
`endif

// *** design/kmp_top.v ***
/*
  Two identical keyboard/mouse serial ports behind an APB slave, with interrupt status and mask.
  Assumes open-drain clock and data lines pulled up outside; pins are asynchronous to pclk.
*/
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "kmp_regs.vh"
// What this block does
// RQ1 - Two identical ports, keyboard and mouse
// RQ2 - Characters pass unchanged both ways
// RQ3 - Four byte registers per port
// RQ4 - Hardwired identifier in low four bits
// RQ5 - Any reset write empties buffers, machines
// RQ6 - Soft reset leaves external device alone
// RQ7 - After soft reset control reads zero
// RQ8 - Read returns oldest, removes one character
// RQ9 - Status bit0 high while characters buffered
// RQ10 - Interrupt only on empty to nonempty
// RQ11 - Host reads until nonempty flag clears
// RQ12 - Four character receive buffer, arrival order
// RQ13 - ID/reset and data registers share offsets
// RQ14 - Disabled port receives nothing, no interrupts
// RQ15 - One pending transmit; writes ignored while pending
// RQ16 - Finish receiving before taking link
// RQ17 - Port interrupts ORed, mirrored status bit4
// RQ18 - Start, eight bits LSB first, odd parity, stop

module kmp_port #(
  parameter [3:0] PORT_ID = 4'h0,
  parameter [31:0] TMO_CYC = `KMP_TMO_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire wr_id,
  input wire wr_data,
  input wire wr_ctrl,
  input wire rd_data,
  input wire [7:0] wdata,
  input wire cmp_irq,
  output wire [7:0] rd_id,
  output wire [7:0] rd_rx,
  output wire [7:0] rd_ctrl,
  output wire [7:0] rd_stat,
  output wire port_irq,
  output wire rx_event,
  input wire kb_clk_i,
  output wire kb_clk_o,
  output wire kb_clk_oe_n,
  input wire kb_dat_i,
  output wire kb_dat_o,
  output wire kb_dat_oe_n
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RX = 3'd1;
  localparam [2:0] S_INH = 3'd2;
  localparam [2:0] S_TX = 3'd3;
  localparam [2:0] S_ACK = 3'd4;
  reg [1:0] clk_s_q;
  reg [1:0] dat_s_q;
  reg clk_prev_q;
  reg [7:0] ctrl_q;
  reg [7:0] rxbuf_q [0:`KMP_RX_DEPTH-1];
  reg [1:0] rd_ptr_q;
  reg [2:0] cnt_q;
  reg perr_q;
  reg terr_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [9:0] sh_q;
  reg [7:0] tx_q;
  reg txp_q;
  reg [31:0] tim_q;
  reg drv_clk_q;
  reg drv_dat_q;
  reg lclk_q;
  reg [7:0] ldiv_q;
  reg [7:0] rx_q;
  integer i;
  wire loop = ctrl_q[`KMP_CTRL_LOOP];
  wire on = ctrl_q[`KMP_CTRL_ON];
  wire line_clk = loop ? lclk_q : clk_s_q[1];
  wire line_dat = loop ? drv_dat_q : dat_s_q[1];
  wire fall = clk_prev_q & ~line_clk;
  wire rx_push = (st_q == S_RX) && fall && (bit_q == 4'd9) && (cnt_q != 3'd4);
  wire rx_pop = rd_data && (cnt_q != 3'd0);
  wire par_bad = ~^sh_q[9:1];
  // RQ2 byte passes unchanged
  always @* rx_q = sh_q[8:1];

  function odd_par;
    input [7:0] b;
    begin
      odd_par = ~^b;
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s_q <= 2'b11;
      dat_s_q <= 2'b11;
    end else begin
      clk_s_q <= {clk_s_q[0], kb_clk_i};
      dat_s_q <= {dat_s_q[0], kb_dat_i};
    end
  end

  // RQ5 RQ7 soft reset control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `KMP_CTRL_RESET;
    end else if (wr_id) begin
      ctrl_q <= `KMP_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  // Loopback internal clock, 2 MHz
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldiv_q <= 8'h00;
      lclk_q <= 1'b1;
    end else if (!loop || st_q == S_IDLE || st_q == S_INH) begin
      ldiv_q <= 8'h00;
      lclk_q <= 1'b1;
    end else if (ldiv_q == (`KMP_LOOP_DIV - 1)) begin
      ldiv_q <= 8'h00;
      lclk_q <= ~lclk_q;
    end else begin
      ldiv_q <= ldiv_q + 8'h01;
    end
  end

  // RQ12 RQ8 four deep buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `KMP_RX_DEPTH; i = i + 1) begin
        rxbuf_q[i] <= 8'h00;
      end
      rd_ptr_q <= 2'd0;
      cnt_q <= 3'd0;
    end else if (wr_id) begin
      rd_ptr_q <= 2'd0;
      cnt_q <= 3'd0;
    end else begin
      if (rx_push) begin
        rxbuf_q[rd_ptr_q + cnt_q[1:0]] <= rx_q;
      end
      if (rx_pop) begin
        rd_ptr_q <= rd_ptr_q + 2'd1;
      end
      cnt_q <= cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
    end
  end

  // RQ18 RQ16 RQ15 link state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      bit_q <= 4'd0;
      sh_q <= 10'h000;
      tx_q <= 8'h00;
      txp_q <= 1'b0;
      tim_q <= 32'd0;
      drv_clk_q <= 1'b1;
      drv_dat_q <= 1'b1;
      clk_prev_q <= 1'b1;
      perr_q <= 1'b0;
      terr_q <= 1'b0;
    end else if (wr_id) begin
      // RQ6 only lines released
      st_q <= S_IDLE;
      bit_q <= 4'd0;
      txp_q <= 1'b0;
      tim_q <= 32'd0;
      drv_clk_q <= 1'b1;
      drv_dat_q <= 1'b1;
      clk_prev_q <= 1'b1;
      perr_q <= 1'b0;
      terr_q <= 1'b0;
    end else begin
      clk_prev_q <= line_clk;
      // RQ15 ignore writes while pending
      if (wr_data && !txp_q) begin
        tx_q <= wdata;
        txp_q <= 1'b1;
      end
      tim_q <= (st_q == S_IDLE) ? 32'd0 : tim_q + 32'd1;
      case (st_q)
        S_IDLE: begin
          bit_q <= 4'd0;
          if (txp_q) begin
            st_q <= S_INH;
            drv_clk_q <= 1'b0;
          // RQ14 no reception while disabled
          end else if (on && !perr_q && fall && !line_dat) begin
            st_q <= S_RX;
          end
        end
        S_RX: begin
          if (fall) begin
            sh_q <= {line_dat, sh_q[9:1]};
            bit_q <= bit_q + 4'd1;
            // RQ18 stop bit ends frame
            if (bit_q == 4'd9) begin
              perr_q <= par_bad ? 1'b1 : perr_q;
              st_q <= S_IDLE;
              drv_clk_q <= ~par_bad;
            end
          end else if (tim_q >= TMO_CYC) begin
            terr_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_INH: begin
          if (tim_q >= `KMP_INHIBIT_CYC) begin
            drv_dat_q <= 1'b0;
            drv_clk_q <= 1'b1;
            sh_q <= {1'b1, odd_par(tx_q), tx_q};
            st_q <= S_TX;
            tim_q <= 32'd0;
          end
        end
        S_TX: begin
          if (fall) begin
            drv_dat_q <= sh_q[0];
            sh_q <= {1'b1, sh_q[9:1]};
            bit_q <= bit_q + 4'd1;
            if (bit_q == 4'd9) begin
              st_q <= S_ACK;
            end
          end else if (tim_q >= TMO_CYC) begin
            terr_q <= 1'b1;
            drv_dat_q <= 1'b1;
            txp_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_ACK: begin
          drv_dat_q <= 1'b1;
          if (fall || loop || tim_q >= TMO_CYC) begin
            txp_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  wire diag = ctrl_q[`KMP_CTRL_DIAG];
  wire pin_clk = diag ? ctrl_q[`KMP_CTRL_CLK] : (loop | drv_clk_q);
  wire pin_dat = diag ? ctrl_q[`KMP_CTRL_DAT] : (loop | drv_dat_q);
  assign kb_clk_o = 1'b0;
  assign kb_dat_o = 1'b0;
  assign kb_clk_oe_n = pin_clk;
  assign kb_dat_oe_n = pin_dat;

  // RQ4 hardwired identifier
  assign rd_id = {4'h0, PORT_ID};
  assign rd_rx = rxbuf_q[rd_ptr_q];
  assign rd_ctrl = ctrl_q;
  // RQ9 RQ17 status view
  assign rd_stat = {clk_s_q[1], dat_s_q[1], 1'b0, cmp_irq, perr_q, terr_q, txp_q, cnt_q != 3'd0};
  // RQ10 RQ14 level until empty
  assign port_irq = on && (cnt_q != 3'd0);
  assign rx_event = on && rx_push && (cnt_q == 3'd0);
endmodule // kmp_port

module kmp_top #(
  parameter [31:0] TMO_CYC = `KMP_TMO_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire kbd_clk_i,
  output wire kbd_clk_o,
  output wire kbd_clk_oe_n,
  input wire kbd_dat_i,
  output wire kbd_dat_o,
  output wire kbd_dat_oe_n,
  input wire mse_clk_i,
  output wire mse_clk_o,
  output wire mse_clk_oe_n,
  input wire mse_dat_i,
  output wire mse_dat_o,
  output wire mse_dat_oe_n
);
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire glob = paddr[9];
  wire [1:0] psel_v;
  wire [1:0] pirq;
  wire [1:0] pev;
  wire [7:0] rid [0:1];
  wire [7:0] rrx [0:1];
  wire [7:0] rct [0:1];
  wire [7:0] rst [0:1];
  wire [1:0] cin = {mse_clk_i, kbd_clk_i};
  wire [1:0] din = {mse_dat_i, kbd_dat_i};
  wire [1:0] co;
  wire [1:0] coe;
  wire [1:0] dout;
  wire [1:0] doe;
  reg [1:0] ist_q;
  reg [1:0] imask_q;
  reg cmp_prev_q;
  // RQ17 composite of both ports
  wire cmp = |pirq;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  genvar g;
  // RQ1 two identical ports
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      wire hit = ~glob & (paddr[`KMP_PORT_SEL_BIT] == g);
      // RQ13 RQ3 offset decode
      kmp_port #(.PORT_ID(g == 0 ? `KMP_ID_KBD : `KMP_ID_MSE), .TMO_CYC(TMO_CYC)) u_port (
        .pclk(pclk),
        .presetn(presetn),
        .wr_id(wr & hit & (paddr[3:0] == `KMP_OFF_ID)),
        .wr_data(wr & hit & (paddr[3:0] == `KMP_OFF_DATA)),
        .wr_ctrl(wr & hit & (paddr[3:0] == `KMP_OFF_CTRL)),
        .rd_data(rd & hit & (paddr[3:0] == `KMP_OFF_DATA)),
        .wdata(pwdata[7:0]),
        .cmp_irq(cmp),
        .rd_id(rid[g]),
        .rd_rx(rrx[g]),
        .rd_ctrl(rct[g]),
        .rd_stat(rst[g]),
        .port_irq(pirq[g]),
        .rx_event(pev[g]),
        .kb_clk_i(cin[g]),
        .kb_clk_o(co[g]),
        .kb_clk_oe_n(coe[g]),
        .kb_dat_i(din[g]),
        .kb_dat_o(dout[g]),
        .kb_dat_oe_n(doe[g])
      );
    end
  endgenerate
  assign kbd_clk_o = co[0];
  assign kbd_clk_oe_n = coe[0];
  assign kbd_dat_o = dout[0];
  assign kbd_dat_oe_n = doe[0];
  assign mse_clk_o = co[1];
  assign mse_clk_oe_n = coe[1];
  assign mse_dat_o = dout[1];
  assign mse_dat_oe_n = doe[1];

  // RQ17 sticky bit on rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 2'b00;
      imask_q <= 2'b00;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= cmp;
      if (wr && paddr[11:0] == `KMP_OFF_IRQ_MASK) begin
        imask_q <= pwdata[1:0];
      end
      ist_q <= (ist_q & ~((wr && paddr[11:0] == `KMP_OFF_IRQ_STAT) ? pwdata[1:0] : 2'b00))
        | {pev[1], cmp & ~cmp_prev_q};
    end
  end
  assign irq = |(ist_q & imask_q);

  wire pi = paddr[`KMP_PORT_SEL_BIT];
  always @* begin
    prdata = 32'h0000_0000;
    if (glob) begin
      if (paddr[11:0] == `KMP_OFF_IRQ_STAT) prdata = {30'h0, ist_q};
      else if (paddr[11:0] == `KMP_OFF_IRQ_MASK) prdata = {30'h0, imask_q};
    end else begin
      case (paddr[3:0])
        `KMP_OFF_ID: prdata = {24'h0, rid[pi]};
        `KMP_OFF_DATA: prdata = {24'h0, rrx[pi]};
        `KMP_OFF_CTRL: prdata = {24'h0, rct[pi]};
        `KMP_OFF_STAT: prdata = {24'h0, rst[pi]};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // kmp_top

// *** tb/kmp_sva.sv ***
/*
  Checker for the keyboard/mouse port pair, bound to kmp_top.
  Assumes an APB master that holds each request until pready.
*/
`timescale 1ns/100ps
module kmp_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire kbd_clk_o,
  input wire kbd_dat_o,
  input wire kbd_clk_oe_n,
  input wire kbd_dat_oe_n
);
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_KBD_ID: assert property (rd && paddr == 12'h000 |-> prdata[3:0] == 4'h5)
    else $error("keyboard id wrong");
  AST_MSE_ID: assert property (rd && paddr == 12'h100 |-> prdata[3:0] == 4'ha)
    else $error("mouse id wrong");
  AST_BYTE: assert property (rd && paddr[7:4] == 4'h0 |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not answered");
  AST_OPEN_DRAIN: assert property (!kbd_clk_o && !kbd_dat_o)
    else $error("line driven high");
  AST_SRST_FREE: assert property (wr && paddr == 12'h000 |-> ##[1:3] (kbd_clk_oe_n && kbd_dat_oe_n))
    else $error("lines held after soft reset");
  AST_SRST_EMPTY: assert property (wr && paddr == 12'h000 ##[1:4] rd && paddr == 12'h00c |->
    prdata[1:0] == 2'h0) else $error("buffers not empty after soft reset");
  AST_SRST_OFF: assert property (wr && paddr == 12'h000 ##[1:8] rd && paddr == 12'h008 |->
    prdata[7:0] == 8'h00) else $error("control not zero after soft reset");
endmodule // kmp_sva

bind kmp_top kmp_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .kbd_clk_o(kbd_clk_o), .kbd_dat_o(kbd_dat_o), .kbd_clk_oe_n(kbd_clk_oe_n),
  .kbd_dat_oe_n(kbd_dat_oe_n));

// *** tb/kmp_dev.sv ***
/*
  Behavioural keyboard or mouse on one clock/data pair.
  Assumes the bench resolves each line as a wired-and with a pull-up.
*/
`timescale 1ns/100ps
module kmp_dev (
  input wire clk_l,
  input wire dat_l,
  output reg clk_d,
  output reg dat_d,
  output reg [7:0] got,
  output reg got_ok
);
  reg busy;
  reg [9:0] sh;
  integer i;
  initial begin
    clk_d = 1'h1;
    dat_d = 1'h1;
    busy = 1'h0;
    got = 8'h00;
    got_ok = 1'h0;
  end
  task send(input [7:0] b, input bad);
    reg [10:0] f;
    integer k;
    begin
      busy = 1'h1;
      f = {1'h1, ~^b ^ bad, b, 1'h0};
      for (k = 0; k < 11; k = k + 1) begin
        dat_d = f[k];
        #200 clk_d = 1'h0;
        #200 clk_d = 1'h1;
      end
      #200 busy = 1'h0;
    end
  endtask
  // frame from host, no reset action
  always @(posedge clk_l) begin
    #1;
    if (!busy && !dat_l) begin
      got_ok = 1'h0;
      for (i = 0; i < 10; i = i + 1) begin
        #200 clk_d = 1'h0;
        #200 clk_d = 1'h1;
        #100 sh[i] = dat_l;
      end
      dat_d = 1'h0;
      #100 clk_d = 1'h0;
      #200 clk_d = 1'h1;
      dat_d = 1'h1;
      got = sh[7:0];
      got_ok = ^sh[8:0] & sh[9];
    end
  end
endmodule // kmp_dev

// *** tb/test_kmp_top.sv ***
/*
  Directed bench for kmp_top over APB with a device model on each port.
  Assumes pull-ups on every link line.
*/
`timescale 1ns/100ps
module test_kmp_top;
  reg pclk, presetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, irq, kco, kcoe_n, kdo, kdoe_n, mco, mcoe_n, mdo, mdoe_n;
  wire kcd, kdd, mcd, mdd, kok;
  wire [7:0] kgot;
  wire kcl = (kcoe_n | kco) & kcd;
  wire kdl = (kdoe_n | kdo) & kdd;
  wire mcl = (mcoe_n | mco) & mcd;
  wire mdl = (mdoe_n | mdo) & mdd;
  integer n_fail, checked, n;
  reg [7:0] r, b;
  kmp_top #(.TMO_CYC(200)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .kbd_clk_i(kcl), .kbd_clk_o(kco), .kbd_clk_oe_n(kcoe_n),
    .kbd_dat_i(kdl), .kbd_dat_o(kdo), .kbd_dat_oe_n(kdoe_n), .mse_clk_i(mcl), .mse_clk_o(mco),
    .mse_clk_oe_n(mcoe_n), .mse_dat_i(mdl), .mse_dat_o(mdo), .mse_dat_oe_n(mdoe_n));
  kmp_dev kdev (.clk_l(kcl), .dat_l(kdl), .clk_d(kcd), .dat_d(kdd), .got(kgot), .got_ok(kok));
  kmp_dev mdev (.clk_l(mcl), .dat_l(mdl), .clk_d(mcd), .dat_d(mdd), .got(), .got_ok());
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  task print_verdict;
    begin
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task hang;
    begin
      n_fail = n_fail + 1;
      $display("Error at %0t: timeout", $time);
      print_verdict;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      r = prdata[7:0];
      psel <= 1'h0;
      penable <= 1'h0;
      if (k == 20)
        hang;
    end
  endtask
  task rdc(input [11:0] a, input [7:0] m, input [7:0] e);
    begin
      apb(1'h0, a, 8'h00);
      chk(r & m, e);
    end
  endtask
  task irqc(input [7:0] e);
    begin
      @(negedge pclk);
      chk({7'h00, irq}, e);
    end
  endtask
  task wait_irq;
    integer k;
    begin
      for (k = 0; k < 100 && irq !== 1'h1; k = k + 1)
        @(posedge pclk);
      if (k == 100)
        hang;
    end
  endtask
  initial begin
    n_fail = 0;
    checked = 0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rdc(12'h000, 8'h0f, 8'h05);
    rdc(12'h100, 8'h0f, 8'h0a);
    rdc(12'h008, 8'hff, 8'h00);
    rdc(12'h00c, 8'h1f, 8'h00);
    rdc(12'h300, 8'hff, 8'h00);
    $display("reset test done");
    apb(1'h1, 12'h204, 8'h01);
    apb(1'h1, 12'h008, 8'h01);
    kdev.send(8'h11, 1'h0);
    wait_irq;
    apb(1'h1, 12'h200, 8'h01);
    irqc(8'h00);
    for (b = 8'h22; b != 8'h66; b = b + 8'h11)
      kdev.send(b, 1'h0);
    irqc(8'h00);
    rdc(12'h00c, 8'h13, 8'h11);
    for (b = 8'h11; b != 8'h55; b = b + 8'h11)
      rdc(12'h004, 8'hff, b);
    rdc(12'h00c, 8'h11, 8'h00);
    kdev.send(8'h66, 1'h0);
    wait_irq;
    rdc(12'h004, 8'hff, 8'h66);
    apb(1'h1, 12'h200, 8'h01);
    $display("receive test done");
    mdev.send(8'h77, 1'h0);
    rdc(12'h10c, 8'h01, 8'h00);
    irqc(8'h00);
    apb(1'h1, 12'h108, 8'h01);
    mdev.send(8'h78, 1'h0);
    wait_irq;
    rdc(12'h10c, 8'h11, 8'h11);
    rdc(12'h00c, 8'h11, 8'h10);
    rdc(12'h104, 8'hff, 8'h78);
    apb(1'h1, 12'h200, 8'h03);
    $display("mouse test done");
    apb(1'h1, 12'h004, 8'ha5);
    rdc(12'h00c, 8'h02, 8'h02);
    apb(1'h1, 12'h004, 8'h3c);
    r = 8'h02;
    for (n = 0; n < 2000 && (r[1] || !kok); n = n + 1)
      apb(1'h0, 12'h00c, 8'h00);
    if (n == 2000)
      hang;
    chk(kgot, 8'ha5);
    chk({7'h00, kok}, 8'h01);
    rdc(12'h00c, 8'h02, 8'h00);
    $display("transmit test done");
    kdev.send(8'h99, 1'h0);
    apb(1'h1, 12'h000, 8'hff);
    rdc(12'h00c, 8'h03, 8'h00);
    rdc(12'h008, 8'hff, 8'h00);
    $display("soft reset test done");
    print_verdict;
  end
endmodule // test_kmp_top
